// ---- hdl/pmc_panel_mode_controller.sv ----
// Front-panel mode controller: modes, selections, levels, options and indicators.
//
// Behaviour
// - Two exclusive modes; each mode button enters its mode; controls act on it.
// - Input button enters input mode, or toggles channel when already there.
// - Output button enters output mode, or toggles speaker/headphone when already there.
// - Knob press in input mode toggles the selected channel.
// - Knob press in output mode with speaker selected toggles speaker mute.
// - Mute never silences headphones; press with headphones selected keeps mute.
// - Muted speaker shows red selection indicator and red ring when speaker selected.
// - Clockwise knob in output mode raises the selected output volume.
// - Clockwise knob in input mode raises the selected channel gain, or both gains while linked.
// - Ring shows gain of selected channel or volume of selected output.
// - Six option settings per channel; buttons change the selected channel, or both while linked.
// - Option indicators are dim, bright, or unlit when unavailable.
// - Output mode ignores option buttons and leaves option indicators unlit.
// - Instrument plug forces channel 1 to instrument source; never channel 2.
// - Source option button alternates selected channel between mic and line.
// - Source is one-hot; source indicators show the selected channel's source.
// - Speaker and headphone volumes are separate; rotation changes only the selected one.
// - Panel gain, source and option changes affect the selected channel, or both channels while linked.
// - Software may change every panel setting in any mode.
// - Link cannot be enabled with instrument plugged; linked adjustments hit both channels.
//
// The placing of the registers and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ns
module pmc_panel_mode_controller #(
  parameter int LW = pmc_pkg::LEVEL_W
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic in_mode_btn,
  input wire logic out_mode_btn,
  input wire logic knob_press,
  input wire logic knob_cw,
  input wire logic knob_ccw,
  input wire logic [pmc_pkg::NUM_OPT-1:0] opt_btn,
  input wire logic inst_plug,
  input wire logic [pmc_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic [LW-1:0] ring_level,
  output logic ring_red,
  output logic first_channel_indicator,
  output logic second_channel_indicator,
  output logic spk_sel_green,
  output logic spk_sel_red,
  output logic hp_sel_ind,
  output logic [2:0] src_ind,
  output logic [2*pmc_pkg::NUM_OPT-1:0] opt_ind,
  output logic [2:0] ch1_src,
  output logic [2:0] ch2_src,
  output logic [LW-1:0] gain1,
  output logic [LW-1:0] gain2,
  output logic [LW-1:0] spk_vol,
  output logic [LW-1:0] hp_vol,
  output logic spk_mute
);
  import pmc_pkg::*;

  // Pin inputs pass three flops; an edge is taken once the second and third agree.
  localparam int NPIN = 5 + NUM_OPT;
  logic [NPIN-1:0] pin_s1;
  logic [NPIN-1:0] pin_s2;
  logic [NPIN-1:0] pin_s3;
  logic [NPIN-1:0] pin_lvl;
  logic [NPIN-1:0] pin_rise;
  logic inst_lvl;

  pmc_mode_t mode;
  logic chan;
  logic out_hp;
  logic [LW-1:0] gain [2];
  logic [NUM_OPT-2:0] opts [2];
  logic line_sel [2];

  always_ff @(posedge clk) begin
    if (rst) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
      pin_s3 <= '0;
      pin_lvl <= '0;
      inst_lvl <= 1'b0;
    end else if (ce) begin
      pin_s1 <= {inst_plug, in_mode_btn, out_mode_btn, knob_press, knob_cw, opt_btn[0], opt_btn[1],
                 opt_btn[2], opt_btn[3], opt_btn[4], opt_btn[5]};
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      for (int i = 0; i < NPIN; i++) begin
        if (pin_s2[i] == pin_s3[i]) begin
          pin_lvl[i] <= pin_s3[i];
        end
      end
      inst_lvl <= pin_lvl[NPIN-1];
    end
  end

  // Counter-clockwise uses its own synchroniser; it shares the agreement rule.
  logic ccw_s1;
  logic ccw_s2;
  logic ccw_s3;
  logic ccw_lvl;
  logic ccw_prev;
  logic [NPIN-1:0] pin_prev;
  always_ff @(posedge clk) begin
    if (rst) begin
      ccw_s1 <= 1'b0;
      ccw_s2 <= 1'b0;
      ccw_s3 <= 1'b0;
      ccw_lvl <= 1'b0;
      ccw_prev <= 1'b0;
      pin_prev <= '0;
    end else if (ce) begin
      ccw_s1 <= knob_ccw;
      ccw_s2 <= ccw_s1;
      ccw_s3 <= ccw_s2;
      if (ccw_s2 == ccw_s3) begin
        ccw_lvl <= ccw_s3;
      end
      ccw_prev <= ccw_lvl;
      pin_prev <= pin_lvl;
    end
  end

  assign pin_rise = pin_lvl & ~pin_prev;

  logic ev_in;
  logic ev_out;
  logic ev_press;
  logic ev_cw;
  logic ev_ccw;
  logic [NUM_OPT-1:0] ev_opt;
  assign ev_in = pin_rise[NPIN-2];
  assign ev_out = pin_rise[NPIN-3];
  assign ev_press = pin_rise[NPIN-4];
  assign ev_cw = pin_rise[NPIN-5];
  assign ev_ccw = ccw_lvl & ~ccw_prev;
  always_comb begin
    for (int i = 0; i < NUM_OPT; i++) begin
      ev_opt[i] = pin_rise[NUM_OPT-1-i];
    end
  end

  // Saturating step: rotation stops at the ends instead of wrapping.
  function automatic logic [LW-1:0] step(input logic [LW-1:0] v, input logic up, input logic dn);
    logic [LW-1:0] r;
    r = v;
    if (up && v != LW'(LEVEL_MAX)) begin
      r = v + LW'(1);
    end else if (dn && v != '0) begin
      r = v - LW'(1);
    end
    return r;
  endfunction

  logic sw_wr_panel;
  assign sw_wr_panel = reg_wr && reg_addr == REG_PANEL;
  logic linked;
  assign linked = opts[0][OPT_LINK-1] | opts[1][OPT_LINK-1];
  logic in_act;
  assign in_act = mode == PMC_MODE_INPUT;

  // Mode, channel and output selection.
  always_ff @(posedge clk) begin
    if (rst) begin
      mode <= PMC_MODE_INPUT;
      chan <= 1'b0;
      out_hp <= 1'b0;
    end else if (ce) begin
      if (sw_wr_panel) begin
        mode <= reg_wdata[PANEL_MODE] ? PMC_MODE_OUTPUT : PMC_MODE_INPUT;
        chan <= reg_wdata[PANEL_CHAN];
        out_hp <= reg_wdata[PANEL_OUT];
      end else if (ev_in) begin
        if (in_act) begin
          chan <= ~chan;
        end else begin
          mode <= PMC_MODE_INPUT;
        end
      end else if (ev_out) begin
        if (!in_act) begin
          out_hp <= ~out_hp;
        end else begin
          mode <= PMC_MODE_OUTPUT;
        end
      end else if (ev_press && in_act) begin
        chan <= ~chan;
      end
    end
  end

  // Speaker mute and output volumes.
  always_ff @(posedge clk) begin
    if (rst) begin
      spk_mute <= 1'b0;
      spk_vol <= VOL_RST;
      hp_vol <= VOL_RST;
    end else if (ce) begin
      if (sw_wr_panel) begin
        spk_mute <= reg_wdata[PANEL_MUTE];
      end else if (ev_press && !in_act && !out_hp) begin
        spk_mute <= ~spk_mute;
      end
      if (reg_wr && reg_addr == REG_SPK_VOL) begin
        spk_vol <= reg_wdata[LW-1:0];
      end else if (!in_act && !out_hp) begin
        spk_vol <= step(spk_vol, ev_cw, ev_ccw);
      end
      if (reg_wr && reg_addr == REG_HP_VOL) begin
        hp_vol <= reg_wdata[LW-1:0];
      end else if (!in_act && out_hp) begin
        hp_vol <= step(hp_vol, ev_cw, ev_ccw);
      end
    end
  end

  // Per-channel gain, source and options; link copies panel changes to both channels.
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int c = 0; c < 2; c++) begin
        gain[c] <= GAIN_RST;
        opts[c] <= '0;
        line_sel[c] <= 1'b0;
      end
    end else if (ce) begin
      for (int c = 0; c < 2; c++) begin
        if (reg_wr && reg_addr == (c == 0 ? REG_GAIN1 : REG_GAIN2)) begin
          gain[c] <= reg_wdata[LW-1:0];
        end else if (in_act && (chan == c[0] || linked)) begin
          gain[c] <= step(gain[c], ev_cw, ev_ccw);
        end
        if (reg_wr && reg_addr == (c == 0 ? REG_OPT1 : REG_OPT2)) begin
          opts[c] <= reg_wdata[NUM_OPT-2:0];
          line_sel[c] <= reg_wdata[OPTREG_LINE];
          if (inst_lvl) begin
            opts[c][OPT_LINK-1] <= 1'b0;
          end
        end else if (in_act && (chan == c[0] || linked)) begin
          if (ev_opt[OPT_SRC]) begin
            line_sel[c] <= ~line_sel[c];
          end
          for (int k = 1; k < NUM_OPT - 1; k++) begin
            if (ev_opt[k]) begin
              opts[c][k-1] <= ~opts[c][k-1];
            end
          end
          if (ev_opt[OPT_LINK] && !inst_lvl) begin
            opts[c][OPT_LINK-1] <= ~opts[c][OPT_LINK-1];
          end
        end
      end
    end
  end

  // Active source: instrument overrides channel 1 only; otherwise mic or line, one-hot.
  logic [2:0] src_c [2];
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      src_c[c] = '0;
      if (c == 0 && inst_lvl) begin
        src_c[c][SRC_INST] = 1'b1;
      end else if (line_sel[c]) begin
        src_c[c][SRC_LINE] = 1'b1;
      end else begin
        src_c[c][SRC_MIC] = 1'b1;
      end
    end
  end

  // Availability: phantom and pad need the mic source; link needs no instrument.
  logic [NUM_OPT-1:0] avail;
  logic [NUM_OPT-1:0] active;
  always_comb begin
    avail = '1;
    avail[OPT_PHANTOM] = src_c[chan][SRC_MIC];
    avail[OPT_PAD] = src_c[chan][SRC_MIC];
    avail[OPT_LINK] = !inst_lvl;
    active = {opts[chan], 1'b1};
  end

  // Indicator and level outputs, all registered.
  always_ff @(posedge clk) begin
    if (rst) begin
      ring_level <= '0;
      ring_red <= 1'b0;
      first_channel_indicator <= 1'b0;
      second_channel_indicator <= 1'b0;
      spk_sel_green <= 1'b0;
      spk_sel_red <= 1'b0;
      hp_sel_ind <= 1'b0;
      src_ind <= '0;
      opt_ind <= '0;
      ch1_src <= '0;
      ch2_src <= '0;
      gain1 <= '0;
      gain2 <= '0;
    end else if (ce) begin
      ring_level <= in_act ? gain[chan] : (out_hp ? hp_vol : spk_vol);
      ring_red <= !in_act && !out_hp && spk_mute;
      first_channel_indicator <= in_act && !chan;
      second_channel_indicator <= in_act && chan;
      spk_sel_green <= !in_act && !out_hp && !spk_mute;
      spk_sel_red <= !in_act && !out_hp && spk_mute;
      hp_sel_ind <= !in_act && out_hp;
      src_ind <= src_c[chan];
      for (int k = 0; k < NUM_OPT; k++) begin
        if (!in_act || !avail[k]) begin
          opt_ind[2*k +: 2] <= IND_OFF;
        end else begin
          opt_ind[2*k +: 2] <= active[k] ? IND_BRIGHT : IND_DIM;
        end
      end
      ch1_src <= src_c[0];
      ch2_src <= src_c[1];
      gain1 <= gain[0];
      gain2 <= gain[1];
    end
  end

  // Read port: data stand in the cycle after the read strobe.
  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata <= '0;
    end else if (ce) begin
      reg_rdata <= '0;
      if (reg_rd) begin
        case (reg_addr)
          REG_PANEL: reg_rdata <= {4'h0, spk_mute, out_hp, chan, mode == PMC_MODE_OUTPUT};
          REG_GAIN1: reg_rdata <= 8'(gain[0]);
          REG_GAIN2: reg_rdata <= 8'(gain[1]);
          REG_SPK_VOL: reg_rdata <= 8'(spk_vol);
          REG_HP_VOL: reg_rdata <= 8'(hp_vol);
          REG_OPT1: reg_rdata <= {2'h0, line_sel[0], opts[0]};
          REG_OPT2: reg_rdata <= {2'h0, line_sel[1], opts[1]};
          REG_STATUS: reg_rdata <= {4'h0, inst_lvl, src_c[chan]};
          default: reg_rdata <= '0;
        endcase
      end
    end
  end
endmodule

// ---- hdl/pmc_pkg.sv ----
// Shared constants and types for the front-panel mode controller.
package pmc_pkg;
  localparam int LEVEL_W = 7;
  localparam logic [LEVEL_W-1:0] LEVEL_MAX = 7'h7f;
  localparam logic [LEVEL_W-1:0] GAIN_RST = 7'h00;
  localparam logic [LEVEL_W-1:0] VOL_RST = 7'h00;
  localparam int NUM_OPT = 6;
  // Option button positions.
  localparam int OPT_SRC = 0;
  localparam int OPT_FILTER = 1;
  localparam int OPT_PHANTOM = 2;
  localparam int OPT_PAD = 3;
  localparam int OPT_POLARITY = 4;
  localparam int OPT_LINK = 5;
  // One-hot source positions.
  localparam int SRC_MIC = 0;
  localparam int SRC_LINE = 1;
  localparam int SRC_INST = 2;
  // Register offsets of the software port.
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] REG_PANEL = 4'h0;
  localparam logic [ADDR_W-1:0] REG_GAIN1 = 4'h1;
  localparam logic [ADDR_W-1:0] REG_GAIN2 = 4'h2;
  localparam logic [ADDR_W-1:0] REG_SPK_VOL = 4'h3;
  localparam logic [ADDR_W-1:0] REG_HP_VOL = 4'h4;
  localparam logic [ADDR_W-1:0] REG_OPT1 = 4'h5;
  localparam logic [ADDR_W-1:0] REG_OPT2 = 4'h6;
  localparam logic [ADDR_W-1:0] REG_STATUS = 4'h7;
  // Bits of the panel register.
  localparam int PANEL_MODE = 0;
  localparam int PANEL_CHAN = 1;
  localparam int PANEL_OUT = 2;
  localparam int PANEL_MUTE = 3;
  // Bits of the option registers: 0..4 options, 5 line source.
  localparam int OPTREG_LINE = 5;
  // Indicator encodings.
  localparam logic [1:0] IND_OFF = 2'h0;
  localparam logic [1:0] IND_DIM = 2'h1;
  localparam logic [1:0] IND_BRIGHT = 2'h2;
  typedef enum logic {PMC_MODE_INPUT, PMC_MODE_OUTPUT} pmc_mode_t;
endpackage

// ---- tb/pmc_checker_sva.sv ----
// Concurrent checks on the ports of the panel mode controller.
`timescale 1ns/1ns
module pmc_checker #(
  parameter int LW = pmc_pkg::LEVEL_W
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [pmc_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic [LW-1:0] ring_level,
  input wire logic ring_red,
  input wire logic first_channel_indicator,
  input wire logic second_channel_indicator,
  input wire logic spk_sel_green,
  input wire logic spk_sel_red,
  input wire logic hp_sel_ind,
  input wire logic [2*pmc_pkg::NUM_OPT-1:0] opt_ind,
  input wire logic [2:0] ch1_src,
  input wire logic [2:0] ch2_src,
  input wire logic [LW-1:0] gain1,
  input wire logic [LW-1:0] hp_vol,
  input wire logic spk_mute
);
  import pmc_pkg::*;
  logic [1:0] up;
  // Indicators trail the state by a cycle, so shape checks wait for them to settle.
  always_ff @(posedge clk) begin
    if (rst) begin
      up <= 2'h0;
    end else if (up != 2'h3) begin
      up <= up + 2'h1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_one_mode_lit: assert property (up == 2'h3 |-> $onehot({first_channel_indicator, second_channel_indicator,
    spk_sel_green, spk_sel_red, hp_sel_ind}))
    else $error("selection indicators not exactly one");
  a_opt_dark_out: assert property ((spk_sel_green | spk_sel_red | hp_sel_ind) |-> opt_ind == '0)
    else $error("option indicators lit in output mode");
  a_src_one_hot: assert property (up == 2'h3 |-> $onehot(ch1_src) && $onehot(ch2_src))
    else $error("source not one-hot");
  a_ch2_no_inst: assert property (!ch2_src[SRC_INST])
    else $error("second channel took instrument");
  a_red_when_muted: assert property (ring_red == spk_sel_red && (!spk_sel_red || $past(spk_mute)))
    else $error("red indicators disagree with mute");
  // The ring and the gain copy are loaded at the same edge, so they are compared in the same cycle.
  a_ring_gain_one: assert property (first_channel_indicator |-> ring_level == gain1)
    else $error("ring not showing channel one gain");
  a_ring_hp_vol: assert property (hp_sel_ind |-> ring_level == $past(hp_vol))
    else $error("ring not showing headphone volume");
  a_host_hp_write: assert property (ce && reg_wr && reg_addr == REG_HP_VOL |=>
    {1'b0, hp_vol} == ($past(reg_wdata) & 8'h7f))
    else $error("host volume write lost");
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside read slot");
  a_unmapped_zero: assert property ($past(reg_rd) && $past(reg_addr) > REG_STATUS |-> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
endmodule
bind pmc_panel_mode_controller pmc_checker #(.LW(LW)) chk_u (.clk(clk), .rst(rst), .ce(ce), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ring_level(ring_level),
  .ring_red(ring_red), .first_channel_indicator(first_channel_indicator),
  .second_channel_indicator(second_channel_indicator), .spk_sel_green(spk_sel_green),
  .spk_sel_red(spk_sel_red), .hp_sel_ind(hp_sel_ind), .opt_ind(opt_ind), .ch1_src(ch1_src),
  .ch2_src(ch2_src), .gain1(gain1), .hp_vol(hp_vol), .spk_mute(spk_mute));

// ---- tb/pmc_panel_model.sv ----
// Behavioural panel: buttons and push-button encoder pressed on command.
`timescale 1ns/1ns
module pmc_panel_model (
  input wire logic clk,
  input wire logic go,
  input wire logic [3:0] sel,
  output logic [10:0] pins
);
  logic [3:0] cnt;
  initial begin
    pins = 11'h0;
    cnt = 4'h0;
  end
  // Each contact stays closed, then open, for six cycles; levels shorter than two cycles would be lost in the synchroniser.
  always @(posedge clk) begin
    if (go) begin
      pins <= 11'h1 << sel;
      cnt <= 4'hc;
    end else if (cnt != 4'h0) begin
      cnt <= cnt - 4'h1;
      if (cnt == 4'h7) pins <= 11'h0;
    end
  end
endmodule

// ---- tb/test_panel_mode_controller.sv ----
// Self-checking bench for the panel mode controller.
`timescale 1ns/1ns
module test_panel_mode_controller;
  import pmc_pkg::*;
  logic clk, rst, ce, inst_plug, reg_wr, reg_rd, go, ring_red, spk_mute;
  logic first_channel_indicator, second_channel_indicator, spk_sel_green, spk_sel_red, hp_sel_ind;
  logic [3:0] sel, reg_addr;
  logic [10:0] pins;
  logic [7:0] reg_wdata, reg_rdata, d;
  logic [6:0] ring_level, gain1, gain2, spk_vol, hp_vol;
  logic [2:0] src_ind, ch1_src, ch2_src;
  logic [11:0] opt_ind;
  int err_count, checked, seed;
  int seq[13] = '{3, 0, 4, 2, 1, 2, 1, 2, 3, 7, 1, 0, 5};
  logic m_out, m_ch, m_hp, m_mute, m_plug;
  logic [1:0] m_line;
  logic [6:0] m_gain[2];
  logic [6:0] m_vol[2];
  logic [4:0] m_opt[2];
  pmc_panel_model pan_u (.clk(clk), .go(go), .sel(sel), .pins(pins));
  pmc_panel_mode_controller dut_u (.clk(clk), .rst(rst), .ce(ce), .in_mode_btn(pins[0]), .out_mode_btn(pins[1]),
    .knob_press(pins[2]), .knob_cw(pins[3]), .knob_ccw(pins[4]), .opt_btn(pins[10:5]), .inst_plug(inst_plug),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .ring_level(ring_level), .ring_red(ring_red), .first_channel_indicator(first_channel_indicator),
    .second_channel_indicator(second_channel_indicator), .spk_sel_green(spk_sel_green), .spk_sel_red(spk_sel_red),
    .hp_sel_ind(hp_sel_ind), .src_ind(src_ind), .opt_ind(opt_ind), .ch1_src(ch1_src), .ch2_src(ch2_src),
    .gain1(gain1), .gain2(gain2), .spk_vol(spk_vol), .hp_vol(hp_vol), .spk_mute(spk_mute));
  function automatic logic [6:0] step(logic [6:0] v, logic inc);
    if (inc) return (v == LEVEL_MAX) ? v : v + 7'h1;
    return (v == 7'h00) ? v : v - 7'h1;
  endfunction
  function automatic logic [2:0] src_of(logic c);
    if (!c && m_plug) return 3'h4;
    return m_line[c] ? 3'h2 : 3'h1;
  endfunction
  // Phantom and pad need the mic source, link needs an empty instrument jack; the source option is lit bright in input mode.
  function automatic logic [11:0] opt_exp();
    logic [11:0] e;
    logic av;
    logic on;
    e = '0;
    for (int k = 0; k < 6; k++) begin
      av = (k == 2 || k == 3) ? src_of(m_ch) == 3'h1 : (k == 5 ? !m_plug : 1'b1);
      if (k == 0) on = 1'b1;
      else on = m_opt[m_ch][k-1];
      e[2*k +: 2] = (m_out || !av) ? IND_OFF : (on ? IND_BRIGHT : IND_DIM);
    end
    return e;
  endfunction
  task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic check_all();
    logic [11:0] oe;
    oe = opt_exp();
    chk("gain1", {1'b0, m_gain[0]}, {1'b0, gain1});
    chk("gain2", {1'b0, m_gain[1]}, {1'b0, gain2});
    chk("spk_vol", {1'b0, m_vol[0]}, {1'b0, spk_vol});
    chk("hp_vol", {1'b0, m_vol[1]}, {1'b0, hp_vol});
    chk("mute", {7'h0, m_mute}, {7'h0, spk_mute});
    chk("ch1_src", {5'h0, src_of(0)}, {5'h0, ch1_src});
    chk("ch2_src", {5'h0, src_of(1)}, {5'h0, ch2_src});
    chk("src_ind", {5'h0, src_of(m_ch)}, {5'h0, src_ind});
    chk("chan_ind", {6'h0, !m_out && !m_ch, !m_out && m_ch}, {6'h0, first_channel_indicator,
      second_channel_indicator});
    chk("out_ind", {4'h0, m_out && !m_hp && !m_mute, m_out && !m_hp && m_mute, m_out && m_hp,
      m_out && !m_hp && m_mute}, {4'h0, spk_sel_green, spk_sel_red, hp_sel_ind, ring_red});
    chk("opt_lo", oe[7:0], opt_ind[7:0]);
    chk("opt_hi", {4'h0, oe[11:8]}, {4'h0, opt_ind[11:8]});
    chk("ring", {1'b0, m_out ? m_vol[m_hp] : m_gain[m_ch]}, {1'b0, ring_level});
    if (m_out) chk("opt_dark", 8'h0, {7'h0, |opt_ind});
  endtask
  task automatic act(int a);
    logic lk;
    lk = m_opt[0][4] | m_opt[1][4];
    @(posedge clk);
    sel <= a[3:0];
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    case (a)
      0: if (m_out) m_out = 0; else m_ch = !m_ch;
      1: if (!m_out) m_out = 1; else m_hp = !m_hp;
      2: if (!m_out) m_ch = !m_ch; else if (!m_hp) m_mute = !m_mute;
      3, 4: if (m_out) m_vol[m_hp] = step(m_vol[m_hp], a == 3);
      default: ;
    endcase
    // Input adjustments reach the selected channel, or both while linked.
    for (int c = 0; c < 2; c++) begin
      if (!m_out && (c == m_ch || lk)) begin
        if (a == 3 || a == 4) m_gain[c] = step(m_gain[c], a == 3);
        if (a == 5) m_line[c] = !m_line[c];
        if (a >= 6 && a <= 9) m_opt[c][a-6] = !m_opt[c][a-6];
        if (a == 10 && !m_plug) m_opt[c][4] = !m_opt[c][4];
      end
    end
    repeat (16) @(posedge clk);
    check_all();
  endtask
  task automatic wr(logic [3:0] a, logic [7:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(logic [3:0] a, output logic [7:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    wrap_up();
  end
  initial begin
    seed = 32'hb4bfaedb;
    {rst, inst_plug, reg_wr, reg_rd, go, sel, reg_addr, reg_wdata} = '0;
    {m_out, m_ch, m_hp, m_mute, m_plug, m_line} = '0;
    m_gain = '{7'h0, 7'h0};
    m_vol = '{7'h0, 7'h0};
    m_opt = '{5'h0, 5'h0};
    ce = 1'b1;
    rst = 1'b1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    check_all();
    rd(REG_PANEL, d);
    chk("panel", 8'h00, d);
    foreach (seq[i]) act(seq[i]);
    wr(REG_PANEL, 8'h09);
    {m_mute, m_hp, m_ch, m_out} = 4'h9;
    d = 8'($random(seed));
    wr(REG_GAIN2, d);
    m_gain[1] = d[6:0];
    wr(REG_SPK_VOL, 8'h7f);
    m_vol[0] = 7'h7f;
    d = 8'($random(seed));
    wr(REG_HP_VOL, d);
    m_vol[1] = d[6:0];
    act(3);
    rd(REG_PANEL, d);
    chk("panel", 8'h09, d);
    wr(4'hf, 8'hff);
    rd(4'hf, d);
    chk("unmapped", 8'h00, d);
    // A write while the clock enable is low must leave every setting frozen.
    ce <= 1'b0;
    wr(REG_HP_VOL, 8'h55);
    ce <= 1'b1;
    check_all();
    wr(REG_PANEL, 8'h00);
    {m_mute, m_hp, m_ch, m_out} = 4'h0;
    inst_plug <= 1'b1;
    m_plug = 1;
    act(10);
    rd(REG_OPT1, d);
    chk("link", 8'h00, {7'h0, d[4]});
    act(5);
    inst_plug <= 1'b0;
    m_plug = 0;
    repeat (60) act($unsigned($random(seed)) % 11);
    wrap_up();
  end
endmodule
